//--- include/btch_pkg.sv
// constants, types and field layout shared by the block transfer handler
// assumes a 16-bit word stream, 64-word blocks in both directions
package btch_pkg;
  localparam int unsigned BLK_WORDS = 64;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned AW = 6;
  localparam int unsigned SLOTS = 32;
  localparam int unsigned SLOT_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned DATA_WORDS = 62;
  localparam logic [5:0] W_ID = 6'h00;
  localparam logic [5:0] W_REQ = 6'h01;
  localparam logic [5:0] W_DATA0 = 6'h02;
  localparam logic [5:0] W_LAST = 6'h3f;
  localparam logic [5:0] W_P1_BAUD = 6'h01;
  localparam logic [5:0] W_P1_CNT = 6'h02;
  localparam logic [5:0] W_P2_BAUD = 6'h0b;
  localparam logic [5:0] W_P2_CNT = 6'h0c;
  localparam logic [5:0] W_ENT_FIRST = 6'h01;
  localparam logic [5:0] W_ENT_LAST = 6'h20;
  localparam logic [15:0] ID_PORT1 = 16'h0000;
  localparam logic [15:0] ID_PORT2 = 16'h0001;
  localparam logic [15:0] ID_CONFIG = 16'h00ff;
  localparam logic [15:0] ID_NONE = 16'hffff;
  localparam logic [15:0] RD_ID = 16'h0000;
  localparam logic [15:0] BAUD_LAST = 16'h0007;
  localparam logic [15:0] BAUD_19K2 = 16'h0006;
  localparam logic [15:0] BAUD_38K4 = 16'h0007;
  localparam logic [15:0] CNT_MAX = 16'h0020;
  localparam logic [7:0] EN_ON = 8'h01;
  localparam logic [7:0] SEL_OFFSET = 8'h80;
  localparam logic [15:0] BAUD_TAB [8] = '{16'h012c, 16'h0258, 16'h04b0, 16'h0960,
                                          16'h12c0, 16'h2580, 16'h4b00, 16'h9600};

  typedef enum logic [1:0] {
    BTCH_STG_CLEAR,
    BTCH_STG_START,
    BTCH_STG_SEND
  } btch_stage_e;

  typedef struct packed {
    logic valid;
    logic [7:0] select;
    btch_stage_e cmd;
  } btch_poll_req_s;

  typedef struct packed {
    logic [15:0] baud;
    logic [CNT_W-1:0] slaves;
  } btch_port_cfg_s;
endpackage

//--- verilog/btch_port_poller.sv
// per-port poll list and polling sequencer, one per serial port
// assumes the serial engine acks each request once it is sent
`timescale 1ns/1ps
module btch_port_poller
  import btch_pkg::*;
#(
  parameter int unsigned N = SLOTS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [CNT_W-1:0] slaves_i,
  input wire logic ent_we_i,
  input wire logic [SLOT_W-1:0] ent_idx_i,
  input wire logic [WORD_W-1:0] ent_i,
  input wire logic ack_i,
  output btch_poll_req_s req_o
);
  typedef struct packed {
    logic [N-1:0] en;
    logic [N-1:0][7:0] adr;
    btch_stage_e [N-1:0] stg;
    logic [SLOT_W-1:0] idx;
    btch_poll_req_s req;
  } btch_pp_s;

  btch_pp_s s_q;
  btch_pp_s s_d;

  always_comb begin
    s_d = s_q;
    if (ent_we_i) begin
      // a newly enabled slave restarts with a clear-buffer command
      if (ent_i[15:8] == EN_ON && !s_q.en[ent_idx_i]) begin
        s_d.stg[ent_idx_i] = BTCH_STG_CLEAR;
      end
      s_d.en[ent_idx_i] = (ent_i[15:8] == EN_ON);
      s_d.adr[ent_idx_i] = ent_i[7:0];
    end
    if (s_q.req.valid) begin
      if (ack_i) begin
        s_d.req.valid = 1'b0;
        s_d.idx = s_q.idx + 1'b1;
        if (s_q.stg[s_q.idx] == BTCH_STG_CLEAR) begin
          s_d.stg[s_q.idx] = BTCH_STG_START;
        end else begin
          s_d.stg[s_q.idx] = BTCH_STG_SEND;
        end
      end
    end else if (run_i) begin
      if ({1'b0, s_q.idx} >= slaves_i) begin
        s_d.idx = '0;
      end else if (s_q.en[s_q.idx]) begin
        s_d.req.valid = 1'b1;
        s_d.req.select = s_q.adr[s_q.idx] + SEL_OFFSET;
        s_d.req.cmd = s_q.stg[s_q.idx];
      end else begin
        s_d.idx = s_q.idx + 1'b1;
      end
    end
    if (restart_i) begin
      // the list itself survives a reconfiguration, only the sequence restarts
      for (int i = 0; i < N; i++) begin
        s_d.stg[i] = BTCH_STG_CLEAR;
      end
      s_d.req.valid = 1'b0;
      s_d.idx = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_o = s_q.req;

  property p_sel;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(s_q.req.valid) |-> s_q.req.select == s_q.adr[s_q.idx] + SEL_OFFSET;
  endproperty
  a_sel: assert property (p_sel) else $error("bad counter select");

  property p_restart;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    restart_i |=> !s_q.req.valid && s_q.stg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept stage");

  sequence s_ack_clear;
    s_q.req.valid && ack_i && s_q.stg[s_q.idx] == BTCH_STG_CLEAR && !restart_i && !ent_we_i;
  endsequence
  property p_stage;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_ack_clear |=> s_q.stg[$past(s_q.idx)] == BTCH_STG_START;
  endproperty
  a_stage: assert property (p_stage) else $error("stage did not advance");

  property p_halt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !run_i && !s_q.req.valid |=> !s_q.req.valid;
  endproperty
  a_halt: assert property (p_halt) else $error("poll issued while halted");
endmodule

//--- verilog/btch_block_handler.sv
// block transfer command handler: decodes 64-word write blocks and serves read blocks
// assumes the processor writes whole blocks in word order, word 63 last
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
// What this block does
// - write block word 0 is the identifier, words 1 to 63 the payload
// - identifier 0 is port one list, 1 port two list, 255 configuration
// - before configuration, read word 1 holds 255
// - keep transferring until configured, then run or request poll lists
// - any later accepted configuration restarts all polling from clear-buffer
// - configuration words 1-10 port one, 11-20 port two: baud, count, spare
// - baud codes 0-7 map to 300 up to 38400 baud
// - one port at 19200 with the other at 38400 is a configuration error
// - slave count 0 to 32 limits the polling search; the data space is fixed at 62 words
// - list block identifier picks the port; words 1-32 are slave entries
// - entry high byte 1 enables polling, low byte is counter address
// - enable changes take effect at run time without reconfiguration
// - counter select sends address plus 128, addresses from zero
// - read word 0 is read block id, word 1 requested write block id
// - read word 1 asks for list block 0 or 1; processor answers
// - polled results are held in a data space and read out in blocks
// - transfers and polling stop while the processor is out of run mode
module btch_block_handler
  import btch_pkg::*;
#(
  parameter int unsigned N = SLOTS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic run_mode_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WORD_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [WORD_W-1:0] rdata_o,
  output logic configured_o,
  output logic cfg_err_o,
  output btch_port_cfg_s [1:0] cfg_o,
  output btch_poll_req_s [1:0] poll_req_o,
  input wire logic [1:0] poll_ack_i,
  input wire logic res_we_i,
  input wire logic [AW-1:0] res_addr_i,
  input wire logic [WORD_W-1:0] res_data_i
);
  typedef struct packed {
    logic [WORD_W-1:0] wid;
    logic [WORD_W-1:0] p1b;
    logic [WORD_W-1:0] p1c;
    logic [WORD_W-1:0] p2b;
    logic [WORD_W-1:0] p2c;
    logic cfgd;
    logic err;
    logic restart;
    logic req_id;
    logic [WORD_W-1:0] rdata;
    btch_port_cfg_s [1:0] cfg;
    logic [1:0] ent_we;
    logic [SLOT_W-1:0] ent_idx;
    logic [WORD_W-1:0] ent;
    logic [DATA_WORDS-1:0][WORD_W-1:0] data;
  } btch_top_s;

  btch_top_s s_q;
  btch_top_s s_d;

  logic wr_ok;
  logic rd_ok;
  logic [WORD_W-1:0] cur_id;
  logic commit;
  logic cfg_good;

  // baud code to rate; codes above the table are caught by the range check
  function automatic logic [15:0] baud_of(input logic [15:0] code);
    logic [2:0] c;
    c = code[2:0];
    return BAUD_TAB[c];
  endfunction

  function automatic logic mixed_top(input logic [15:0] a, input logic [15:0] b);
    return (a == BAUD_19K2 && b == BAUD_38K4) || (a == BAUD_38K4 && b == BAUD_19K2);
  endfunction

  // out of run mode the processor stops transferring; strobes are ignored
  assign wr_ok = wr_i && run_mode_i;
  assign rd_ok = rd_i && run_mode_i;
  assign cur_id = (addr_i == W_ID) ? wdata_i : s_q.wid;
  assign commit = wr_ok && addr_i == W_LAST && cur_id == ID_CONFIG;

  always_comb begin
    cfg_good = 1'b1;
    if (s_q.p1b > BAUD_LAST || s_q.p2b > BAUD_LAST) begin
      cfg_good = 1'b0;
    end
    if (s_q.p1c > CNT_MAX || s_q.p2c > CNT_MAX) begin
      cfg_good = 1'b0;
    end
    if (mixed_top(s_q.p1b, s_q.p2b)) begin
      cfg_good = 1'b0;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.ent_we = '0;
    if (wr_ok) begin
      if (addr_i == W_ID) begin
        // anything but the three known codes parks the block as ignored
        if (wdata_i == ID_PORT1 || wdata_i == ID_PORT2 || wdata_i == ID_CONFIG) begin
          s_d.wid = wdata_i;
        end else begin
          s_d.wid = ID_NONE;
        end
      end else if (s_q.wid == ID_CONFIG) begin
        unique case (addr_i)
          W_P1_BAUD: s_d.p1b = wdata_i;
          W_P1_CNT: s_d.p1c = wdata_i;
          W_P2_BAUD: s_d.p2b = wdata_i;
          W_P2_CNT: s_d.p2c = wdata_i;
          default: s_d.p1b = s_q.p1b;
        endcase
      end else if (s_q.wid == ID_PORT1 || s_q.wid == ID_PORT2) begin
        // entries go straight to the poller so enables act at once
        if (addr_i >= W_ENT_FIRST && addr_i <= W_ENT_LAST) begin
          s_d.ent_we[s_q.wid[0]] = 1'b1;
          s_d.ent_idx = SLOT_W'(addr_i - W_ENT_FIRST);
          s_d.ent = wdata_i;
        end
      end
    end
    if (commit) begin
      if (cfg_good) begin
        s_d.cfg[0].baud = baud_of(s_q.p1b);
        s_d.cfg[1].baud = baud_of(s_q.p2b);
        s_d.cfg[0].slaves = s_q.p1c[CNT_W-1:0];
        s_d.cfg[1].slaves = s_q.p2c[CNT_W-1:0];
        s_d.cfgd = 1'b1;
        s_d.err = 1'b0;
        s_d.restart = 1'b1;
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (rd_ok) begin
      if (addr_i == W_ID) begin
        s_d.rdata = RD_ID;
      end else if (addr_i == W_REQ) begin
        if (s_q.cfgd) begin
          s_d.rdata = {15'h0000, s_q.req_id};
        end else begin
          s_d.rdata = ID_CONFIG;
        end
      end else begin
        s_d.rdata = s_q.data[addr_i - W_DATA0];
      end
      // alternate the list request between the ports once per read block
      if (addr_i == W_LAST && s_q.cfgd) begin
        s_d.req_id = ~s_q.req_id;
      end
    end
    if (res_we_i && res_addr_i >= W_DATA0) begin
      s_d.data[res_addr_i - W_DATA0] = res_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign configured_o = s_q.cfgd;
  assign cfg_err_o = s_q.err;
  assign cfg_o = s_q.cfg;

  for (genvar p = 0; p < 2; p++) begin : g_port
    btch_port_poller #(
      .N(N)
    ) u_poller (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .run_i(run_mode_i && s_q.cfgd),
      .restart_i(s_q.restart),
      .slaves_i(s_q.cfg[p].slaves),
      .ent_we_i(s_q.ent_we[p]),
      .ent_idx_i(s_q.ent_idx),
      .ent_i(s_q.ent),
      .ack_i(poll_ack_i[p]),
      .req_o(poll_req_o[p])
    );
  end

  property p_unconf;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rd_ok && addr_i == W_REQ && !configured_o |=> rdata_o == ID_CONFIG;
  endproperty
  a_unconf: assert property (p_unconf) else $error("unconfigured word 1 not 255");

  property p_rid;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rd_ok && addr_i == W_ID |=> rdata_o == RD_ID;
  endproperty
  a_rid: assert property (p_rid) else $error("read block id wrong");

  property p_req;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rd_ok && addr_i == W_REQ && configured_o |=> rdata_o[15:1] == '0;
  endproperty
  a_req: assert property (p_req) else $error("requested id not 0 or 1");

  property p_mixed;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    commit && mixed_top(s_q.p1b, s_q.p2b) |=> cfg_err_o && $stable(cfg_o);
  endproperty
  a_mixed: assert property (p_mixed) else $error("mixed top baud accepted");

  sequence s_good_commit;
    commit && cfg_good;
  endsequence
  property p_good;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_good_commit |=> configured_o && !cfg_err_o && s_q.restart ##1 !s_q.restart;
  endproperty
  a_good: assert property (p_good) else $error("configuration not taken");

  property p_count;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_good_commit |=> cfg_o[1].slaves == $past(s_q.p2c[CNT_W-1:0]);
  endproperty
  a_count: assert property (p_count) else $error("slave count not stored");

  property p_baud;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s_good_commit and (s_q.p1b == BAUD_38K4)) |=> cfg_o[0].baud == 16'h9600;
  endproperty
  a_baud: assert property (p_baud) else $error("baud code 7 not 38400");

  property p_ignore;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_i && (!run_mode_i || s_q.wid == ID_NONE) && addr_i != W_ID
      |=> $stable(cfg_o) && $stable(configured_o) && s_q.ent_we == '0;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored block had effect");

  property p_reset_idle;
    @(posedge ref_clk_i) !reset_n_i |=> rdata_o == '0 && !configured_o && !cfg_err_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset not idle");

  property p_rd_halt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !run_mode_i |=> $stable(rdata_o);
  endproperty
  a_rd_halt: assert property (p_rd_halt) else $error("read served out of run");

  property p_id_cfg;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && addr_i == W_ID && wdata_i == ID_CONFIG |=> s_q.wid == ID_CONFIG;
  endproperty
  a_id_cfg: assert property (p_id_cfg) else $error("config id not taken");

  property p_id_port;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && addr_i == W_ID && wdata_i == ID_PORT2 |=> s_q.wid == ID_PORT2;
  endproperty
  a_id_port: assert property (p_id_port) else $error("port id not taken");

  property p_id_other;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && addr_i == W_ID && wdata_i != ID_PORT1 && wdata_i != ID_PORT2
      && wdata_i != ID_CONFIG |=> s_q.wid == ID_NONE;
  endproperty
  a_id_other: assert property (p_id_other) else $error("unknown id not parked");

  property p_p1_baud;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && s_q.wid == ID_CONFIG && addr_i == W_P1_BAUD |=> s_q.p1b == $past(wdata_i);
  endproperty
  a_p1_baud: assert property (p_p1_baud) else $error("port one baud not held");

  property p_p2_cnt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && s_q.wid == ID_CONFIG && addr_i == W_P2_CNT |=> s_q.p2c == $past(wdata_i);
  endproperty
  a_p2_cnt: assert property (p_p2_cnt) else $error("port two count not held");

  property p_ent_p2;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && s_q.wid == ID_PORT2 && addr_i == W_ENT_LAST
      |=> s_q.ent_we == 2'b10 && &s_q.ent_idx && s_q.ent == $past(wdata_i);
  endproperty
  a_ent_p2: assert property (p_ent_p2) else $error("last entry misrouted");

  property p_ent_range;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_ok && s_q.wid == ID_PORT1 && addr_i > W_ENT_LAST |=> s_q.ent_we == '0;
  endproperty
  a_ent_range: assert property (p_ent_range) else $error("spare word made entry");

  property p_toggle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rd_ok && addr_i == W_LAST && configured_o |=> s_q.req_id != $past(s_q.req_id);
  endproperty
  a_toggle: assert property (p_toggle) else $error("list request not alternated");

  property p_data;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rd_ok && addr_i >= W_DATA0 |=> rdata_o == $past(s_q.data[addr_i - W_DATA0]);
  endproperty
  a_data: assert property (p_data) else $error("data word read wrong");

  property p_res;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    res_we_i && res_addr_i >= W_DATA0
      |=> s_q.data[$past(res_addr_i) - W_DATA0] == $past(res_data_i);
  endproperty
  a_res: assert property (p_res) else $error("result not stored");

  property p_reject;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    commit && !cfg_good |=> cfg_err_o && $stable(configured_o) && $stable(cfg_o);
  endproperty
  a_reject: assert property (p_reject) else $error("bad configuration taken");

  property p_quiet;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !commit |=> !s_q.restart && $stable(cfg_o) && $stable(configured_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("configuration moved unasked");

  property p_baud_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s_good_commit and (s_q.p2b == '0)) |=> cfg_o[1].baud == 16'h012c;
  endproperty
  a_baud_low: assert property (p_baud_low) else $error("baud code 0 not 300");

  property p_cnt_p1;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_good_commit |=> cfg_o[0].slaves == $past(s_q.p1c[CNT_W-1:0]);
  endproperty
  a_cnt_p1: assert property (p_cnt_p1) else $error("port one count not stored");
endmodule

//--- sim/btch_proc_model.sv
// processor side model: writes and reads whole 64-word blocks
// assumes the caller loads blk before send and reads rb after fetch
`timescale 1ns/1ps
module btch_proc_model
  import btch_pkg::*;
(
  input wire logic ref_clk_i,
  output logic [AW-1:0] addr_o,
  output logic [WORD_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [WORD_W-1:0] rdata_i
);
  logic [WORD_W-1:0] blk [64];
  logic [WORD_W-1:0] rb [64];
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // id in word 0, always all 64 words, back to back
  task automatic send();
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk_i);
      wr_o <= 1'b1;
      addr_o <= AW'(i);
      wdata_o <= blk[i];
    end
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
  endtask
  // data of the read taken at one edge is seen at the next
  task automatic fetch();
    for (int i = 0; i < 66; i++) begin
      @(posedge ref_clk_i);
      if (i >= 2) rb[i-2] = rdata_i;
      rd_o <= (i < 64);
      addr_o <= AW'(i);
    end
  endtask
endmodule

//--- sim/btch_block_handler_tb.sv
// self-checking bench for the block transfer handler
// assumes the processor model and the handler share one 125 MHz clock
`timescale 1ns/1ps
module btch_block_handler_tb;
  import btch_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic run_mode_i = 1'b1;
  logic [AW-1:0] addr;
  logic [WORD_W-1:0] wdata, rdata_o;
  logic wr, rd, configured_o, cfg_err_o, res_we_i = 1'b0;
  logic [1:0] poll_ack_i = 2'b00;
  logic [AW-1:0] res_addr_i = '0;
  logic [WORD_W-1:0] res_data_i = '0;
  btch_port_cfg_s [1:0] cfg_o;
  btch_poll_req_s [1:0] poll_req_o;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #4 ref_clk_i = ~ref_clk_i;
  btch_block_handler uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .run_mode_i(run_mode_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata_o), .configured_o(configured_o), .cfg_err_o(cfg_err_o),
    .cfg_o(cfg_o), .poll_req_o(poll_req_o), .poll_ack_i(poll_ack_i),
    .res_we_i(res_we_i), .res_addr_i(res_addr_i), .res_data_i(res_data_i));
  btch_proc_model proc (.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata_o));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    // whole run is well under 20000 cycles
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic blk(input logic [15:0] id, input logic [15:0] w1, input logic [15:0] w2,
                     input logic [15:0] w11, input logic [15:0] w12);
    proc.blk = '{default: 16'h0000};
    proc.blk[0] = id;
    proc.blk[1] = w1;
    proc.blk[2] = w2;
    proc.blk[11] = w11;
    proc.blk[12] = w12;
    proc.send();
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic wait_req(input int p);
    int k;
    k = 0;
    while (poll_req_o[p].valid !== 1'b1 && k < 300) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk(16'(poll_req_o[p].valid), 16'h0001);
  endtask
  task automatic t_unconf();
    proc.fetch();
    chk(proc.rb[0], RD_ID);
    chk(proc.rb[1], 16'h00ff);
    blk(16'h0007, 16'h0000, 16'h0001, 16'h0000, 16'h0001);
    chk(16'(configured_o), 16'h0000);
    run_mode_i <= 1'b0;
    blk(16'h00ff, 16'h0000, 16'h0001, 16'h0000, 16'h0001);
    run_mode_i <= 1'b1;
    chk(16'(configured_o), 16'h0000);
    proc.fetch();
    chk(proc.rb[1], 16'h00ff);
    $display("unconfigured test done");
  endtask
  task automatic t_bad_cfg();
    blk(16'h00ff, 16'h0006, 16'h0001, 16'h0007, 16'h0001);
    chk(16'(cfg_err_o), 16'h0001);
    chk(16'(configured_o), 16'h0000);
    blk(16'h00ff, 16'h0000, 16'h0021, 16'h0000, 16'h0001);
    chk(16'(configured_o), 16'h0000);
    blk(16'h00ff, 16'h0008, 16'h0001, 16'h0000, 16'h0001);
    chk(16'(configured_o), 16'h0000);
    $display("bad configuration test done");
  endtask
  task automatic t_baud();
    logic [15:0] w1;
    for (int k = 0; k < 8; k++) begin
      blk(16'h00ff, 16'(k), 16'h0001, 16'h0000, 16'h0020);
      chk(16'(configured_o), 16'h0001);
      chk(16'(cfg_err_o), 16'h0000);
      chk(cfg_o[0].baud, 16'(300 << k));
      chk(cfg_o[1].baud, 16'h012c);
      chk(16'(cfg_o[0].slaves), 16'h0001);
      chk(16'(cfg_o[1].slaves), 16'h0020);
    end
    proc.fetch();
    w1 = proc.rb[1];
    chk(16'(w1 <= 16'h0001), 16'h0001);
    proc.fetch();
    chk(proc.rb[1] ^ w1, 16'h0001);
    $display("baud test done");
  endtask
  task automatic t_poll();
    blk(ID_PORT1, 16'h0105, 16'h0000, 16'h0000, 16'h0000);
    wait_req(0);
    chk(16'(poll_req_o[0].select), 16'h0085);
    chk(16'(poll_req_o[0].cmd), 16'(BTCH_STG_CLEAR));
    poll_ack_i <= 2'b01;
    @(posedge ref_clk_i);
    poll_ack_i <= 2'b00;
    @(posedge ref_clk_i);
    wait_req(0);
    chk(16'(poll_req_o[0].cmd), 16'(BTCH_STG_START));
    poll_ack_i <= 2'b01;
    @(posedge ref_clk_i);
    poll_ack_i <= 2'b00;
    @(posedge ref_clk_i);
    wait_req(0);
    chk(16'(poll_req_o[0].cmd), 16'(BTCH_STG_SEND));
    blk(16'h00ff, 16'h0005, 16'h0001, 16'h0000, 16'h0001);
    wait_req(0);
    chk(16'(poll_req_o[0].cmd), 16'(BTCH_STG_CLEAR));
    blk(ID_PORT1, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
    // a standing request ends only on ack or restart; after it the halted slot stays quiet
    poll_ack_i <= 2'b01;
    @(posedge ref_clk_i);
    poll_ack_i <= 2'b00;
    repeat (4) @(posedge ref_clk_i);
    chk(16'(poll_req_o[0].valid), 16'h0000);
    blk(ID_PORT2, 16'h0103, 16'h0000, 16'h0000, 16'h0000);
    wait_req(1);
    chk(16'(poll_req_o[1].select), 16'h0083);
    // zero slaves: an enabled entry must not be polled
    blk(16'h00ff, 16'h0005, 16'h0000, 16'h0000, 16'h0001);
    blk(ID_PORT1, 16'h0105, 16'h0000, 16'h0000, 16'h0000);
    repeat (8) @(posedge ref_clk_i);
    chk(16'(poll_req_o[0].valid), 16'h0000);
    // an unknown id that looks like port two must not halt its slot
    blk(16'h0101, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    poll_ack_i <= 2'b10;
    @(posedge ref_clk_i);
    poll_ack_i <= 2'b00;
    @(posedge ref_clk_i);
    wait_req(1);
    chk(16'(poll_req_o[1].select), 16'h0083);
    $display("poll test done");
  endtask
  task automatic t_result();
    res_we_i <= 1'b1;
    res_addr_i <= 6'h05;
    res_data_i <= 16'h1234;
    @(posedge ref_clk_i);
    res_we_i <= 1'b0;
    proc.fetch();
    chk(proc.rb[5], 16'h1234);
    $display("result test done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_unconf();
    t_bad_cfg();
    t_baud();
    t_poll();
    t_result();
    stop_test();
  end
endmodule
